// file: include/sbw_pkg.sv
// Shared constants for the byte-lane write masking SRAM core
package sbw_pkg;

    localparam int DATA_W_DEF  = 36;          // One of 8, 9, 18, 36
    localparam int ADDR_W_DEF  = 10;          // Burst address width of the model array
    localparam int NIBBLE_W    = 4;           // Lane width of the 8-bit variant
    localparam int BYTE_W      = 9;           // Lane width of the wider variants
    localparam int NARROW_W    = 8;           // Data width that uses nibble lanes
    localparam int CLK_PERIOD_PS = 5000;      // CLK_IN period, 200 MHz

    // Reset values
    localparam logic RST_OE     = 1'b0;       // Outputs high impedance after reset
    localparam logic RST_SINGLE = 1'b0;       // Output clock pair in use until strap read

    // Write beat sequencer states, one-hot
    typedef enum logic [2:0] {
        W_IDLE  = 3'b001,
        W_BEAT0 = 3'b010,
        W_BEAT1 = 3'b100
    } sbw_wr_state_e;

    // Read output sequencer states, one-hot
    typedef enum logic [3:0] {
        R_IDLE  = 4'b0001,
        R_ARMED = 4'b0010,
        R_WORD0 = 4'b0100,
        R_WORD1 = 4'b1000
    } sbw_rd_state_e;

endpackage

// file: verif/sbw_ctl_model.sv
// Memory controller model: clock pair, commands and write beats
`timescale 1ns/1ps
`default_nettype none
module sbw_ctl_model (
    input  wire logic  clk_in,    // Core clock
    output logic       k_out,     // Positive input clock
    output logic       k_n_out,   // Negative input clock
    output logic       ld_n_out,  // Load, active low
    output logic       rw_out,    // Read when high
    output logic [9:0] addr_out,  // Base address
    output logic [35:0] d_out,    // Write beat
    output logic [3:0] sel_n_out  // Lane selects, active low
);
    initial
    begin
        {k_out, k_n_out, rw_out, addr_out, d_out, sel_n_out} = '0;
        ld_n_out = 1'b1;
    end
    // One K period of four core cycles; beats ride the K and K_N rises
    task automatic kcyc(input logic l, r, input logic [9:0] a, input logic [35:0] d0,
                        input logic [3:0] s0, input logic [35:0] d1, input logic [3:0] s1);
        @(negedge clk_in);
        {k_out, ld_n_out, rw_out, addr_out} = {1'b1, l, r, a};
        {d_out, sel_n_out} = {d0, s0};
        @(negedge clk_in);
        {k_out, ld_n_out, addr_out} = {1'b0, 1'b1, ~a};
        @(negedge clk_in);
        {k_n_out, d_out, sel_n_out} = {1'b1, d1, s1};
        @(negedge clk_in);
        {k_n_out, d_out, sel_n_out} = {1'b0, ~d1, ~s1};
    endtask
endmodule
`default_nettype wire

// file: verif/sbw_sram_checker.sv
// Read port timing checks for the lane masking SRAM core
`timescale 1ns/1ps
`default_nettype none
module sbw_sram_checker #(
    parameter int DATA_W = 36
) (
    input wire logic              CLK_IN,            // Core clock
    input wire logic              RESETN_IN,         // Reset, active low
    input wire logic              K_IN,              // Positive input clock
    input wire logic              K_N_IN,            // Negative input clock
    input wire logic              C_IN,              // Positive output clock
    input wire logic              C_N_IN,            // Negative output clock
    input wire logic              LOAD_SELECT_N_IN,  // Load, active low
    input wire logic              READ_NOT_WRITE_IN, // Read when high
    input wire logic [DATA_W-1:0] Q_OUT,             // Read data
    input wire logic              Q_OE_OUT           // Read drive enable
);
    logic       k_q, kn_q, c_q, cn_q, single_q, strap_q;
    logic [7:0] rd_age_q;
    // Output timing reference follows the strap taken after reset
    wire        c_rise  = single_q ? K_IN & ~k_q : C_IN & ~c_q;
    wire        cn_rise = single_q ? K_N_IN & ~kn_q : C_N_IN & ~cn_q;
    wire        rd_load = K_IN & ~k_q & ~LOAD_SELECT_N_IN & READ_NOT_WRITE_IN;
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            {k_q, kn_q, c_q, cn_q} <= 4'h0;
            {single_q, strap_q} <= 2'h0;
            rd_age_q <= 8'hff;
        end
        else
        begin
            {k_q, kn_q, c_q, cn_q} <= {K_IN, K_N_IN, C_IN, C_N_IN};
            if (!strap_q)
            begin
                single_q <= C_IN & C_N_IN;
                strap_q  <= 1'b1;
            end
            rd_age_q <= rd_load ? 8'h00 : rd_age_q + {7'h0, rd_age_q != 8'hff};
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    AST_RESET_QUIET: assert property ($rose(RESETN_IN) |-> !Q_OE_OUT && Q_OUT == '0)
        else $error("outputs active after reset");
    AST_OE_AFTER_CN: assert property ($rose(Q_OE_OUT) |-> $past(cn_rise))
        else $error("drive enable rose off the negative output clock");
    AST_OE_DROP_AFTER_C: assert property ($fell(Q_OE_OUT) |-> $past(c_rise))
        else $error("drive enable fell off the positive output clock");
    AST_WORD1_ON_C: assert property (Q_OE_OUT && $past(Q_OE_OUT) && $changed(Q_OUT)
        |-> $past(c_rise)) else $error("second word off the positive output clock");
    AST_Q_HOLDS: assert property (!$past(c_rise) && !$past(cn_rise) |-> $stable(Q_OUT))
        else $error("read data moved without an output clock rise");
    AST_READ_ANSWER: assert property (rd_load && !Q_OE_OUT |-> ##[1:12] $rose(Q_OE_OUT))
        else $error("read load not answered");
    AST_OE_WINDOW: assert property ($rose(Q_OE_OUT) |-> Q_OE_OUT[*6] ##1 !Q_OE_OUT)
        else $error("drive enable window length wrong");
    AST_READ_AGE: assert property ($rose(Q_OE_OUT) |-> rd_age_q == 8'h06)
        else $error("first word not at the read latency");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the lane masking SRAM core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_in, resetn, k, k_n, ld_n, rw, oe, oe_l, w1, kq, cr1, cr2, pw, strap;
    logic [9:0]  addr, pa, ax;
    logic [35:0] d, q, pd0, pd1, ev;
    logic [7:0]  q8, ev8;
    logic [8:0]  q9;
    logic [17:0] q18;
    logic [7:0]  mem8 [0:1023];
    logic [7:0]  expq8 [$];
    logic [3:0]  sel_n, ps0, ps1;
    logic [35:0] mem [0:1023];
    logic [35:0] expq [$];
    int          mismatches, cmp_count, cyc;
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    sbw_ctl_model i_ctl (.clk_in(clk_in), .k_out(k), .k_n_out(k_n), .ld_n_out(ld_n),
        .rw_out(rw), .addr_out(addr), .d_out(d), .sel_n_out(sel_n));
    sbw_sram_core #(.DATA_W(36), .ADDR_W(10)) i_dut (.CLK_IN(clk_in), .RESETN_IN(resetn),
        .K_IN(k), .K_N_IN(k_n), .C_IN(k | strap), .C_N_IN(k_n | strap),
        .LOAD_SELECT_N_IN(ld_n), .READ_NOT_WRITE_IN(rw), .ADDR_IN(addr), .D_IN(d),
        .WRITE_SELECT_N_IN(sel_n), .Q_OUT(q), .Q_OE_OUT(oe));
    // Narrower variants share the command stream and the low lanes
    sbw_sram_core #(.DATA_W(8), .ADDR_W(10)) i_dut_w8 (.CLK_IN(clk_in), .RESETN_IN(resetn),
        .K_IN(k), .K_N_IN(k_n), .C_IN(k | strap), .C_N_IN(k_n | strap),
        .LOAD_SELECT_N_IN(ld_n), .READ_NOT_WRITE_IN(rw), .ADDR_IN(addr), .D_IN(d[7:0]),
        .WRITE_SELECT_N_IN(sel_n[1:0]), .Q_OUT(q8), .Q_OE_OUT());
    sbw_sram_core #(.DATA_W(9), .ADDR_W(10)) i_dut_w9 (.CLK_IN(clk_in), .RESETN_IN(resetn),
        .K_IN(k), .K_N_IN(k_n), .C_IN(k | strap), .C_N_IN(k_n | strap),
        .LOAD_SELECT_N_IN(ld_n), .READ_NOT_WRITE_IN(rw), .ADDR_IN(addr), .D_IN(d[8:0]),
        .WRITE_SELECT_N_IN(sel_n[0:0]), .Q_OUT(q9), .Q_OE_OUT());
    sbw_sram_core #(.DATA_W(18), .ADDR_W(10)) i_dut_w18 (.CLK_IN(clk_in), .RESETN_IN(resetn),
        .K_IN(k), .K_N_IN(k_n), .C_IN(k | strap), .C_N_IN(k_n | strap),
        .LOAD_SELECT_N_IN(ld_n), .READ_NOT_WRITE_IN(rw), .ADDR_IN(addr), .D_IN(d[17:0]),
        .WRITE_SELECT_N_IN(sel_n[1:0]), .Q_OUT(q18), .Q_OE_OUT());
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++)
            if (!s[i]) merge[9*i +: 9] = n[9*i +: 9];
    endfunction
    // Nibble lanes of the 8-bit variant
    function automatic logic [7:0] merge8(input logic [7:0] o, n, input logic [1:0] s);
        merge8 = o;
        for (int i = 0; i < 2; i++)
            if (!s[i]) merge8[4*i +: 4] = n[4*i +: 4];
    endfunction
    function automatic logic [35:0] r36();
        r36 = 36'({$urandom, $urandom});
    endfunction
    task automatic results();
        mismatches += expq.size() + expq8.size();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [35:0] got, e);
        cmp_count++;
        if (got !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, got, e);
        end
    endtask
    // Issues one command and the data of the previous write
    task automatic op(input logic l, r, input logic [9:0] a, input logic [35:0] d0,
                      input logic [3:0] s0, input logic [35:0] d1, input logic [3:0] s1);
        i_ctl.kcyc(l, r, a, pd0, ps0, pd1, ps1);
        if (pw)
        begin
            mem[pa] = merge(mem[pa], pd0, ps0);
            mem[pa + 10'h001] = merge(mem[pa + 10'h001], pd1, ps1);
            mem8[pa] = merge8(mem8[pa], pd0[7:0], ps0[1:0]);
            mem8[pa + 10'h001] = merge8(mem8[pa + 10'h001], pd1[7:0], ps1[1:0]);
        end
        pw = !l && !r;
        {pa, pd0, ps0, pd1, ps1} = {a, d0, s0, d1, s1};
    endtask
    task automatic wr(input logic [9:0] a, input logic [35:0] d0, input logic [3:0] s0,
                      input logic [35:0] d1, input logic [3:0] s1);
        op(1'b0, 1'b0, a, d0, s0, d1, s1);
    endtask
    task automatic rd(input logic [9:0] a);
        op(1'b0, 1'b1, a, '0, '0, '0, '0);
        expq.push_back(mem[a]);
        expq.push_back(mem[a + 10'h001]);
        expq8.push_back(mem8[a]);
        expq8.push_back(mem8[a + 10'h001]);
        repeat (3) op(1'b1, 1'b1, '1, '0, '1, '0, '1);
    endtask
    always @(posedge clk_in)
    begin
        {kq, cr1, cr2} <= {k, k & ~kq, cr1};
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    // Word one on the enable rise, word two after the next K rise
    always @(negedge clk_in)
    begin
        if (oe === 1'b1 && (oe_l !== 1'b1 || (w1 && cr2)))
        begin
            w1 = !w1;
            ev = expq.size() > 0 ? expq.pop_front() : 36'hx;
            ev8 = expq8.size() > 0 ? expq8.pop_front() : 8'hx;
            cmp(q, ev);
            cmp({28'h0, q8}, {28'h0, ev8});
            cmp({27'h0, q9}, {27'h0, ev[8:0]});
            cmp({18'h0, q18}, {18'h0, ev[17:0]});
        end
        oe_l = oe;
    end
    initial
    begin
        {resetn, pw, w1, oe_l, kq, cr1, cr2, strap} = '0;
        void'($urandom(32'h83c0_7e83));
        repeat (5) @(negedge clk_in);
        resetn = 1'b1;
        @(negedge clk_in);
        cmp(q, '0);
        cmp({35'h0, oe}, '0);
        $display("done reset");
        wr(10'h005, r36(), 4'h0, r36(), 4'h0);
        rd(10'h005);
        for (int i = 0; i < 4; i++)
        begin
            wr(10'h005, r36(), ~(4'h1 << i), r36(), ~(4'h8 >> i));
            rd(10'h005);
        end
        $display("done lanes");
        wr(10'h005, r36(), 4'hf, r36(), 4'hf);
        rd(10'h005);
        $display("done no lanes");
        wr(10'h3ff, r36(), 4'h0, r36(), 4'h0);
        rd(10'h3ff);
        $display("done wrap");
        wr(10'h014, r36(), 4'h0, r36(), 4'h0);
        wr(10'h016, r36(), 4'h0, r36(), 4'h0);
        rd(10'h014);
        rd(10'h016);
        $display("done back to back");
        for (int i = 0; i < 10; i += 2)
            wr(10'(40 + i), r36(), 4'h0, r36(), 4'h0);
        for (int i = 0; i < 8; i++)
        begin
            ax = 10'(40 + $urandom_range(7));
            wr(ax, r36(), 4'($urandom), r36(), 4'($urandom));
            rd(ax);
        end
        $display("done random");
        // Second reset with the output clock pair strapped high
        strap = 1'b1;
        resetn = 1'b0;
        repeat (5) @(negedge clk_in);
        resetn = 1'b1;
        @(negedge clk_in);
        cmp(q, '0);
        cmp({35'h0, oe}, '0);
        wr(10'h005, r36(), 4'($urandom), r36(), 4'($urandom));
        rd(10'h005);
        $display("done single clock");
        results();
    end
endmodule
bind sbw_sram_core sbw_sram_checker #(.DATA_W(DATA_W)) i_chk (.CLK_IN(CLK_IN),
    .RESETN_IN(RESETN_IN), .K_IN(K_IN), .K_N_IN(K_N_IN), .C_IN(C_IN), .C_N_IN(C_N_IN),
    .LOAD_SELECT_N_IN(LOAD_SELECT_N_IN), .READ_NOT_WRITE_IN(READ_NOT_WRITE_IN),
    .Q_OUT(Q_OUT), .Q_OE_OUT(Q_OE_OUT));
`default_nettype wire

// file: verilog/sbw_lane_ram.sv
// Burst-pair memory array with per-lane active-low write masking
`timescale 1ns/1ps
`default_nettype none
module sbw_lane_ram #(
    parameter int DATA_W = 36,
    parameter int LANES  = 4,
    parameter int ADDR_W = 10
) (
    input  wire logic                clk_in,       // Core clock
    input  wire logic                wr_en_in,     // Beat write strobe
    input  wire logic [LANES-1:0]    wr_lane_n_in, // Active-low lane selects
    input  wire logic [ADDR_W-1:0]   wr_addr_in,   // Word address of the beat
    input  wire logic [DATA_W-1:0]   wr_data_in,   // Beat data
    input  wire logic [ADDR_W-1:0]   rd_addr_in,   // Base address of read burst
    output logic      [DATA_W-1:0]   rd_data0_out, // Word at base
    output logic      [DATA_W-1:0]   rd_data1_out  // Word at base plus one
);
    localparam int LANE_W = DATA_W / LANES;
    localparam int DEPTH  = 1 << ADDR_W;

    wire  [ADDR_W-1:0] rd_addr_p1 = rd_addr_in + {{(ADDR_W-1){1'b0}}, 1'b1};

    // Each lane its own array, written only when its select is low
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        logic [LANE_W-1:0] mem [DEPTH];
        wire               lane_we = wr_en_in & ~wr_lane_n_in[g];
        always_ff @(posedge clk_in)
        begin
            if (lane_we)
            begin
                mem[wr_addr_in] <= wr_data_in[g*LANE_W +: LANE_W];
            end
        end
        assign rd_data0_out[g*LANE_W +: LANE_W] = mem[rd_addr_in];
        assign rd_data1_out[g*LANE_W +: LANE_W] = mem[rd_addr_p1];
    end
endmodule
`default_nettype wire

// file: verilog/sbw_sram_core.sv
// DDR separate-port burst-of-two SRAM core with per-beat lane write masks
//
// Overview of operation
// [R1] 8-bit: nibble selects gate bits 3:0, 7:4
// [R2] 18-bit: byte selects gate 8:0, 17:9
// [R3] 9-bit: one select gates bits 8:0
// [R4] 36-bit: four selects gate four 9-bit lanes
// [R5] All selects high: beat writes nothing
// [R6] Selects sampled separately for each beat
// [R7] Write data on input rises; read on output
// [R8] Deselected, outputs high impedance after power-up
// [R9] Word one at base, word two plus one
// [R10] Beats counted in input cycles after t
// [R11] Controller may park clocks for fast restart
// [R12] Write loads on positive rise, both low
// [R13] Write data at t+1 positive, negative rise
// [R14] Read words at t+1 negative, t+2 positive
// [R15] Output pair tied high: input pair strap
// [R16] Beat masks apply to base, base+1 words
`timescale 1ns/1ps
`default_nettype none
module sbw_sram_core #(
    parameter int DATA_W = sbw_pkg::DATA_W_DEF,
    parameter int ADDR_W = sbw_pkg::ADDR_W_DEF,
    parameter int LANES  = (DATA_W == sbw_pkg::NARROW_W) ? 2 : DATA_W / sbw_pkg::BYTE_W
) (
    input  wire logic              CLK_IN,       // Core clock, 200 MHz
    input  wire logic              RESETN_IN,    // Asynchronous reset, active low
    input  wire logic              K_IN,         // Positive input clock, sampled
    input  wire logic              K_N_IN,       // Negative input clock, sampled
    input  wire logic              C_IN,         // Positive output clock, sampled
    input  wire logic              C_N_IN,       // Negative output clock, sampled
    input  wire logic              LOAD_SELECT_N_IN, // Command load, active low
    input  wire logic              READ_NOT_WRITE_IN, // High read, low write
    input  wire logic [ADDR_W-1:0] ADDR_IN,      // Burst base address
    input  wire logic [DATA_W-1:0] D_IN,         // Write data beat
    input  wire logic [LANES-1:0]  WRITE_SELECT_N_IN, // Byte or nibble lane selects
    output logic      [DATA_W-1:0] Q_OUT,        // Read data
    output logic                   Q_OE_OUT      // Read data drive enable
);
    // Lane widths: nibble lanes for the 8-bit part, 9-bit lanes otherwise
    // [R1] [R2] [R3] [R4]
    localparam int LANE_W = DATA_W / LANES;

    // Edge detection of the sampled clock pins
    logic k_prev_q;
    logic kn_prev_q;
    logic c_prev_q;
    logic cn_prev_q;

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            k_prev_q  <= 1'b0;
            kn_prev_q <= 1'b0;
            c_prev_q  <= 1'b0;
            cn_prev_q <= 1'b0;
        end
        else
        begin
            k_prev_q  <= K_IN;
            kn_prev_q <= K_N_IN;
            c_prev_q  <= C_IN;
            cn_prev_q <= C_N_IN;
        end
    end

    wire k_rise  = K_IN & ~k_prev_q;
    wire kn_rise = K_N_IN & ~kn_prev_q;
    wire c_rise  = C_IN & ~c_prev_q;
    wire cn_rise = C_N_IN & ~cn_prev_q;

    // Single clock strap, caught once after reset release
    logic single_q;
    logic strap_done_q;

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            single_q     <= sbw_pkg::RST_SINGLE;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            single_q     <= C_IN & C_N_IN; // [R15]
            strap_done_q <= 1'b1;
        end
    end

    // Output timing reference: output pair, or input pair in single mode
    wire out_pos_rise = single_q ? k_rise  : c_rise;  // [R7] [R15]
    wire out_neg_rise = single_q ? kn_rise : cn_rise; // [R7] [R15]

    // Command decode on positive input clock rise
    wire load_wr = k_rise & ~LOAD_SELECT_N_IN & ~READ_NOT_WRITE_IN; // [R12]
    wire load_rd = k_rise & ~LOAD_SELECT_N_IN &  READ_NOT_WRITE_IN;

    // Write beat sequencer
    sbw_pkg::sbw_wr_state_e wr_state_q;
    sbw_pkg::sbw_wr_state_e wr_state_d;
    logic [ADDR_W-1:0]  wr_addr_q;
    logic [ADDR_W-1:0]  wr_addr_d;
    logic [ADDR_W-1:0]  nxt_addr_q;
    logic [ADDR_W-1:0]  nxt_addr_d;
    logic               nxt_q;
    logic               nxt_d;

    // Beat 0 on positive rise of t+1, beat 1 on negative rise of t+1
    wire beat0_fire = (wr_state_q == sbw_pkg::W_BEAT0) & k_rise;  // [R10] [R13]
    wire beat1_fire = (wr_state_q == sbw_pkg::W_BEAT1) & kn_rise; // [R10] [R13]
    wire wr_fire    = beat0_fire | beat1_fire; // [R7]

    // Burst word address: base for beat 0, base plus one for beat 1
    wire [ADDR_W-1:0] wr_word_addr = beat1_fire
        ? wr_addr_q + {{(ADDR_W-1){1'b0}}, 1'b1}
        : wr_addr_q; // [R9] [R16]

    // Selects taken with each beat; may differ between the two beats
    wire [LANES-1:0] beat_lane_n = WRITE_SELECT_N_IN; // [R6] [R16]

    always_comb
    begin
        wr_state_d = wr_state_q;
        wr_addr_d  = wr_addr_q;
        nxt_addr_d = nxt_addr_q;
        nxt_d      = nxt_q;
        case (wr_state_q)
            sbw_pkg::W_IDLE:
            begin
                if (load_wr)
                begin
                    wr_addr_d  = ADDR_IN; // [R9]
                    wr_state_d = sbw_pkg::W_BEAT0;
                end
            end
            sbw_pkg::W_BEAT0:
            begin
                if (k_rise)
                begin
                    wr_state_d = sbw_pkg::W_BEAT1;
                    if (load_wr)
                    begin
                        nxt_addr_d = ADDR_IN;
                        nxt_d      = 1'b1;
                    end
                end
            end
            sbw_pkg::W_BEAT1:
            begin
                if (load_wr)
                begin
                    nxt_addr_d = ADDR_IN;
                    nxt_d      = 1'b1;
                end
                if (kn_rise)
                begin
                    if (nxt_q | load_wr)
                    begin
                        wr_addr_d  = load_wr ? ADDR_IN : nxt_addr_q;
                        nxt_d      = 1'b0;
                        wr_state_d = sbw_pkg::W_BEAT0;
                    end
                    else
                    begin
                        wr_state_d = sbw_pkg::W_IDLE;
                    end
                end
            end
            default:
            begin
                wr_state_d = sbw_pkg::W_IDLE;
                nxt_d      = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wr_state_q <= sbw_pkg::W_IDLE;
            wr_addr_q  <= '0;
            nxt_addr_q <= '0;
            nxt_q      <= 1'b0;
        end
        else
        begin
            wr_state_q <= wr_state_d;
            wr_addr_q  <= wr_addr_d;
            nxt_addr_q <= nxt_addr_d;
            nxt_q      <= nxt_d;
        end
    end

    // Array with per-lane gating; all selects high leaves the word intact
    logic [ADDR_W-1:0] rd_addr_q;
    logic [DATA_W-1:0] rd_word0;
    logic [DATA_W-1:0] rd_word1;

    sbw_lane_ram #(
        .DATA_W (DATA_W),
        .LANES  (LANES),
        .ADDR_W (ADDR_W)
    ) u_ram (
        .clk_in       (CLK_IN),
        .wr_en_in     (wr_fire),      // [R5]
        .wr_lane_n_in (beat_lane_n),  // [R1] [R2] [R3] [R4] [R5]
        .wr_addr_in   (wr_word_addr),
        .wr_data_in   (D_IN),
        .rd_addr_in   (rd_addr_q),
        .rd_data0_out (rd_word0),
        .rd_data1_out (rd_word1)
    );

    // Read output sequencer
    sbw_pkg::sbw_rd_state_e rd_state_q;
    sbw_pkg::sbw_rd_state_e rd_state_d;
    logic [ADDR_W-1:0]  rd_addr_d;
    logic [DATA_W-1:0]  q_q;
    logic [DATA_W-1:0]  q_d;
    logic               oe_q;
    logic               oe_d;

    always_comb
    begin
        rd_state_d = rd_state_q;
        rd_addr_d  = rd_addr_q;
        q_d        = q_q;
        oe_d       = oe_q;
        // Tri-state after the positive output rise that follows the last word
        if (out_pos_rise & (rd_state_q != sbw_pkg::R_WORD1))
        begin
            oe_d = 1'b0; // [R8]
        end
        case (rd_state_q)
            sbw_pkg::R_IDLE:
            begin
                if (load_rd)
                begin
                    rd_addr_d  = ADDR_IN; // [R9]
                    rd_state_d = sbw_pkg::R_ARMED;
                end
            end
            sbw_pkg::R_ARMED:
            begin
                if (k_rise)
                begin
                    rd_state_d = sbw_pkg::R_WORD0; // [R10]
                end
            end
            sbw_pkg::R_WORD0:
            begin
                if (out_neg_rise)
                begin
                    q_d        = rd_word0; // [R14]
                    oe_d       = 1'b1;
                    rd_state_d = sbw_pkg::R_WORD1;
                end
            end
            sbw_pkg::R_WORD1:
            begin
                if (out_pos_rise)
                begin
                    q_d        = rd_word1; // [R9] [R14]
                    oe_d       = 1'b1;
                    rd_state_d = sbw_pkg::R_IDLE;
                end
            end
            default:
            begin
                rd_state_d = sbw_pkg::R_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rd_state_q <= sbw_pkg::R_IDLE;
            rd_addr_q  <= '0;
            q_q        <= '0;
            oe_q       <= sbw_pkg::RST_OE; // [R8]
        end
        else
        begin
            rd_state_q <= rd_state_d;
            rd_addr_q  <= rd_addr_d;
            q_q        <= q_d;
            oe_q       <= oe_d;
        end
    end

    assign Q_OUT    = q_q;
    assign Q_OE_OUT = oe_q;
endmodule
`default_nettype wire
